/* pkg/port_mode_pkg.sv */
// port_mode_pkg: register map, field positions and carrier structs
// assumes a 32-bit AXI4-Lite master with an 8-bit byte address
package port_mode_pkg;
    // ==========================================================
    // port numbering
    localparam int NPORT = 7;
    localparam int PORT_A = 0;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;
    // ==========================================================
    // register groups: byte address bits 7:5 pick a group
    localparam logic [2:0] GRP_DIR = 3'h0;   // 0x00 + 4*port
    localparam logic [2:0] GRP_CTL = 3'h1;   // 0x20 + 4*(port-E)
    localparam logic [2:0] GRP_DOUT = 3'h2;  // 0x40 + 4*port
    localparam logic [2:0] GRP_DIN = 3'h3;   // 0x60 + 4*port, read only
    localparam logic [2:0] GRP_MMC = 3'h4;   // 0x80 memory map control
    localparam logic [2:0] NCTL = 3'h3;
    localparam logic [2:0] NPORT_IDX = 3'h7;
    localparam logic [7:0] PORT_D_MASK = 8'h0f;
    localparam int MMC_PERIPH_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // AXI4-Lite carriers
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;
endpackage

/* rtl/port_mode_mux.sv */
// port_mode_mux: per-pin mode selection for seven general ports
// assumes pins and logic-array terms are synchronous to core_clk and
// programming-time settings are static inputs held by the config store
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps

// How it works
// [RQ1] cleared control bit gives host-mapped I/O
// [RQ2] host output pin driven from data out
// [RQ3] host read returns live pin level
// [RQ4] ports without control default host I/O
// [RQ5] array mode drives on term or direction
// [RQ6] software keeps direction zero on array inputs
// [RQ7] address out drives on term or dir&ctl
// [RQ8] nibble address assignment per port, 8-bit option; code fixes whole bytes: G high byte (low with bus_8bit), others low byte
// [RQ9] upper address pins feed arrays, strobe latched
// [RQ10] decode inputs are treated as address inputs
// [RQ11] data bus port disables general I/O
// [RQ12] fixed modes static, others software writable
// [RQ13] direction ORed with term on A,B,C,F
// [RQ14] peripheral buffer only with enable bit set
// [RQ15] scan pins on port E, three enables
// [RQ16] host boots internally before address out
// [RQ17] direction one output, zero input, default input
// [RQ18] control one address out, zero host I/O
// [RQ19] peripheral buffer floats without a select
// [RQ20] configuration registers reset to zero
// [RQ21] one output source per pin by mode
module port_mode_mux (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register bus
    input wire port_mode_pkg::axi_req_t axi_req,
    output port_mode_pkg::axi_rsp_t axi_rsp,
    // host address bus and strobe
    input wire logic [15:0] host_addr,
    input wire logic address_strobe,
    input wire logic bus_8bit,
    // port pins, enable low while driving
    input wire logic [6:0][7:0] pin_in,
    output logic [6:0][7:0] pin_out,
    output logic [6:0][7:0] pin_oe_n,
    // programming-time assignments
    input wire logic [6:0][7:0] array_io_mask,
    input wire logic [6:0][7:0] latch_in_mask,
    input wire logic data_port_en,
    input wire logic [2:0] scan_enable,
    input wire logic [7:0] scan_pin_mask,
    // logic-array terms
    input wire logic [6:0][7:0] array_oe_term,
    input wire logic [6:0][7:0] array_out,
    input wire logic peripheral_select_a,
    input wire logic peripheral_select_b,
    input wire logic [7:0] peri_out,
    input wire logic peri_drive,
    input wire logic [15:0] data_port_out,
    input wire logic data_port_drive,
    input wire logic [7:0] scan_out,
    input wire logic [7:0] scan_drive,
    // towards the logic arrays and host data path
    output logic [6:0][7:0] array_in,
    output logic [15:0] data_port_in,
    output logic memory_map_periph
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [6:0][7:0] dir;
        logic [2:0][7:0] ctl;
        logic [6:0][7:0] dout;
        logic [7:0] mmc;
        logic [15:0] alat;
        logic [6:0][7:0] input_macrocell;
        logic [6:0][7:0] pout;
        logic [6:0][7:0] poe_n;
        logic [6:0][7:0] arr;
        logic [15:0] dpin;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wlane;
        port_mode_pkg::axi_rsp_t rsp;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic [1:0] rst_sync_reg;
    logic rst_core_n;
    logic [6:0][7:0] drv_w;
    logic [6:0][7:0] val_w;
    logic [6:0][7:0] arr_w;
    logic periph_on;
    logic scan_on;

    // ==========================================================
    // reset release through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_reg[1];

    // peripheral buffer owns port F only with the enable bit set
    assign periph_on = st_reg.mmc[port_mode_pkg::MMC_PERIPH_BIT]; // see [RQ14]
    // any one of the three enables hands the scan_pin_mask pins of port E to the scan logic
    assign scan_on = |scan_enable; // see [RQ15]

    // ==========================================================
    // per-pin output multiplexer and array input path
    for (genvar p = 0; p < port_mode_pkg::NPORT; p++) begin : g_port
        for (genvar b = 0; b < 8; b++) begin : g_bit
            logic cb;
            logic ab;
            logic d;
            logic oe_t;
            logic drv;
            logic val;
            localparam bit OE_OR = (p <= port_mode_pkg::PORT_C) ||
                                   (p == port_mode_pkg::PORT_F);
            localparam bit LATCH_OK = (p <= port_mode_pkg::PORT_D) ||
                                      (p == port_mode_pkg::PORT_F);
            assign d = st_reg.dir[p][b];
            assign oe_t = array_oe_term[p][b];
            // ports without a control register never enter address out
            if (p >= port_mode_pkg::PORT_E) begin : g_ctl
                assign cb = st_reg.ctl[p-port_mode_pkg::PORT_E][b];
            end else begin : g_noctl
                assign cb = 1'b0; // see [RQ4]
            end
            // latched address bit for this pin
            if (p == port_mode_pkg::PORT_G && b < 8) begin : g_hi
                assign ab = bus_8bit ? st_reg.alat[b] : st_reg.alat[b+8]; // see [RQ8]
            end else begin : g_lo
                assign ab = st_reg.alat[b]; // see [RQ8]
            end
            // lowest priority first, later modes override
            always_comb begin
                // host I/O: direction, ORed with term where wired
                drv = OE_OR ? (d | oe_t) : d; // see [RQ1] see [RQ13] see [RQ17]
                val = st_reg.dout[p][b]; // see [RQ2]
                if (cb) begin
                    // address out needs term or both dir and ctl
                    drv = oe_t | (d & cb); // see [RQ7] see [RQ18]
                    val = ab;
                end
                if (array_io_mask[p][b]) begin
                    // macrocell or chip select output
                    drv = oe_t | d; // see [RQ5] see [RQ6]
                    val = array_out[p][b];
                end
                if (p == port_mode_pkg::PORT_F && periph_on) begin
                    drv = (peripheral_select_a | peripheral_select_b) & peri_drive; // see [RQ19]
                    val = peri_out[b];
                end
                if ((p == port_mode_pkg::PORT_F || p == port_mode_pkg::PORT_G) &&
                    data_port_en) begin
                    // data bus port, general I/O off
                    drv = data_port_drive; // see [RQ11]
                    val = data_port_out[(p-port_mode_pkg::PORT_F)*8+b];
                end
                if (p == port_mode_pkg::PORT_E && scan_on && scan_pin_mask[b]) begin
                    drv = scan_drive[b];
                    val = scan_out[b];
                end
            end
            assign drv_w[p][b] = drv; // see [RQ21]
            assign val_w[p][b] = val;
            // address inputs to both arrays, optionally strobe latched
            assign arr_w[p][b] = (LATCH_OK && latch_in_mask[p][b]) ?
                                 st_reg.input_macrocell[p][b] : pin_in[p][b]; // see [RQ9] see [RQ10]
        end
    end

    // ==========================================================
    // next state: bus slave, configuration, pin registers
    always_comb begin
        logic [2:0] grp;
        logic [2:0] idx;
        logic [7:0] rv;
        logic ok;
        st_next = st_reg;
        grp = 3'h0;
        idx = 3'h0;
        rv = 8'h00;
        ok = 1'b0;
        // pins and array inputs registered every cycle
        st_next.pout = val_w;
        st_next.poe_n = ~drv_w;
        st_next.arr = arr_w;
        st_next.dpin = {pin_in[port_mode_pkg::PORT_G], pin_in[port_mode_pkg::PORT_F]};
        // address latch and input macrocells follow the strobe
        if (address_strobe) begin
            st_next.alat = host_addr;
            st_next.input_macrocell = pin_in; // see [RQ9]
        end
        // write address and data taken in either order
        if (axi_req.awvalid && st_reg.rsp.awready) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_reg.rsp.wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = axi_req.wdata[7:0];
            st_next.wlane = axi_req.wstrb[0];
        end
        // apply a write once both halves are in
        if (st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid) begin
            grp = st_reg.awaddr[7:5];
            idx = st_reg.awaddr[4:2];
            ok = 1'b1;
            unique case (grp)
                port_mode_pkg::GRP_DIR: begin
                    if (idx < port_mode_pkg::NPORT_IDX) begin
                        if (st_reg.wlane) begin
                            st_next.dir[idx] = (idx == 3'(port_mode_pkg::PORT_D)) ?
                                (st_reg.wdata & port_mode_pkg::PORT_D_MASK) :
                                st_reg.wdata; // see [RQ12]
                        end
                    end else begin
                        ok = 1'b0;
                    end
                end
                port_mode_pkg::GRP_CTL: begin
                    if (idx < port_mode_pkg::NCTL) begin
                        if (st_reg.wlane) begin
                            st_next.ctl[idx] = st_reg.wdata; // see [RQ12] see [RQ16]
                        end
                    end else begin
                        ok = 1'b0;
                    end
                end
                port_mode_pkg::GRP_DOUT: begin
                    if (idx < port_mode_pkg::NPORT_IDX) begin
                        if (st_reg.wlane) begin
                            st_next.dout[idx] = st_reg.wdata;
                        end
                    end else begin
                        ok = 1'b0;
                    end
                end
                port_mode_pkg::GRP_DIN: begin
                    ok = (idx < port_mode_pkg::NPORT_IDX); // writes ignored
                end
                port_mode_pkg::GRP_MMC: begin
                    ok = (idx == 3'h0);
                    if (ok && st_reg.wlane) begin
                        st_next.mmc = st_reg.wdata;
                    end
                end
                default: begin
                    ok = 1'b0;
                end
            endcase
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.rsp.bvalid = 1'b1;
            st_next.rsp.bresp = ok ? port_mode_pkg::RESP_OKAY : port_mode_pkg::RESP_SLVERR;
        end else if (st_reg.rsp.bvalid && axi_req.bready) begin
            st_next.rsp.bvalid = 1'b0;
        end
        // read answer one cycle after the address is taken
        if (axi_req.arvalid && st_reg.rsp.arready) begin
            grp = axi_req.araddr[7:5];
            idx = axi_req.araddr[4:2];
            ok = (idx < port_mode_pkg::NPORT_IDX);
            unique case (grp)
                port_mode_pkg::GRP_DIR: begin
                    rv = ok ? st_reg.dir[idx] : 8'h00;
                end
                port_mode_pkg::GRP_CTL: begin
                    ok = (idx < port_mode_pkg::NCTL);
                    rv = ok ? st_reg.ctl[idx] : 8'h00;
                end
                port_mode_pkg::GRP_DOUT: begin
                    rv = ok ? st_reg.dout[idx] : 8'h00;
                end
                port_mode_pkg::GRP_DIN: begin
                    rv = ok ? pin_in[idx] : 8'h00; // see [RQ3]
                end
                port_mode_pkg::GRP_MMC: begin
                    ok = (idx == 3'h0);
                    rv = ok ? st_reg.mmc : 8'h00;
                end
                default: begin
                    ok = 1'b0;
                end
            endcase
            st_next.rsp.rvalid = 1'b1;
            st_next.rsp.rdata = {24'h000000, rv};
            st_next.rsp.rresp = ok ? port_mode_pkg::RESP_OKAY : port_mode_pkg::RESP_SLVERR;
        end else if (st_reg.rsp.rvalid && axi_req.rready) begin
            st_next.rsp.rvalid = 1'b0;
        end
        // one write and one read in flight at most
        st_next.rsp.awready = !st_next.aw_got && !st_next.rsp.bvalid;
        st_next.rsp.wready = !st_next.w_got && !st_next.rsp.bvalid;
        st_next.rsp.arready = !st_next.rsp.rvalid;
    end

    // ==========================================================
    // state register, everything but poe_n clears at reset
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            st_reg <= '0; // see [RQ20]
            st_reg.poe_n <= {7{8'hff}}; // all pins input
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign axi_rsp = st_reg.rsp;
    assign pin_out = st_reg.pout;
    assign pin_oe_n = st_reg.poe_n;
    assign array_in = st_reg.arr;
    assign data_port_in = st_reg.dpin;
    assign memory_map_periph = st_reg.mmc[port_mode_pkg::MMC_PERIPH_BIT];

endmodule

/* test/pin_world.sv */
// pin_world: far-side pad model for the seven ports
// assumes external devices hold ext_lvl on every line the block leaves free
`timescale 1ns/1ps
module pin_world (
    // pads
    input wire logic [6:0][7:0] pin_out,
    input wire logic [6:0][7:0] pin_oe_n,
    input wire logic [6:0][7:0] ext_lvl,
    // level seen by the block
    output logic [6:0][7:0] pin_in
);
    // ======
    // wire level: block value where enabled, external device level elsewhere
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);
endmodule

/* test/port_mode_mux_asserts.sv */
// port_mode_mux_asserts: pin mode and bus checks on the top ports
// assumes a bind into port_mode_mux and static mode inputs near reset
`timescale 1ns/1ps
module port_mode_mux_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register bus
    input wire port_mode_pkg::axi_req_t axi_req,
    input wire port_mode_pkg::axi_rsp_t axi_rsp,
    // pins
    input wire logic [6:0][7:0] pin_in,
    input wire logic [6:0][7:0] pin_out,
    input wire logic [6:0][7:0] pin_oe_n,
    // modes and terms
    input wire logic [6:0][7:0] array_io_mask,
    input wire logic [6:0][7:0] array_oe_term,
    input wire logic [6:0][7:0] array_out,
    input wire logic data_port_en,
    input wire logic data_port_drive,
    input wire logic [15:0] data_port_out,
    input wire logic peripheral_select_a,
    input wire logic peripheral_select_b,
    input wire logic peri_drive,
    input wire logic [7:0] peri_out,
    input wire logic [2:0] scan_enable,
    input wire logic [7:0] scan_pin_mask,
    input wire logic [7:0] scan_drive,
    input wire logic [7:0] scan_out,
    // results
    input wire logic [15:0] data_port_in,
    input wire logic memory_map_periph
);
    localparam int C = port_mode_pkg::PORT_C;
    localparam int E = port_mode_pkg::PORT_E;
    localparam int F = port_mode_pkg::PORT_F;
    localparam int G = port_mode_pkg::PORT_G;
    // ======
    // cycles since release; internal reset sync still holds the first ones
    logic [2:0] up_reg;
    logic ok;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_reg <= 3'h0;
        end else if (up_reg != 3'h4) begin
            up_reg <= up_reg + 3'h1;
        end
    end
    assign ok = (up_reg == 3'h4);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ======
    // properties
    property p_oe_rst;
        $rose(rst_n) |-> (&pin_oe_n) ##1 (&pin_oe_n);
    endproperty
    a_oe_rst: assert property (p_oe_rst) else $error("pin driven after reset");
    property p_dp_out;
        ok && $past(data_port_en && data_port_drive) |-> {pin_oe_n[G], pin_oe_n[F]} == 16'h0000
            && {pin_out[G], pin_out[F]} == $past(data_port_out);
    endproperty
    a_dp_out: assert property (p_dp_out) else $error("data port not driven");
    property p_dp_in;
        ok && $past(data_port_en) |-> data_port_in == $past({pin_in[G], pin_in[F]});
    endproperty
    a_dp_in: assert property (p_dp_in) else $error("data port input wrong");
    property p_peri;
        ok && memory_map_periph && $past(memory_map_periph && !data_port_en && peri_drive
            && (peripheral_select_a || peripheral_select_b))
            |-> pin_oe_n[F] == 8'h00 && pin_out[F] == $past(peri_out);
    endproperty
    a_peri: assert property (p_peri) else $error("peripheral buffer not driven");
    property p_peri_off;
        ok && memory_map_periph && $past(memory_map_periph && !data_port_en
            && !peripheral_select_a && !peripheral_select_b) |-> pin_oe_n[F] == 8'hff;
    endproperty
    a_peri_off: assert property (p_peri_off) else $error("buffer driven unselected");
    property p_scan;
        ok && $past(|scan_enable) |-> (pin_oe_n[E] & $past(scan_pin_mask & scan_drive)) == 8'h00
            && ((pin_out[E] ^ $past(scan_out)) & $past(scan_pin_mask & scan_drive)) == 8'h00;
    endproperty
    a_scan: assert property (p_scan) else $error("scan pin wrong");
    property p_arr_c;
        ok && $past(|(array_io_mask[C] & array_oe_term[C]))
            |-> (pin_oe_n[C] & $past(array_io_mask[C] & array_oe_term[C])) == 8'h00
            && ((pin_out[C] ^ $past(array_out[C]))
            & $past(array_io_mask[C] & array_oe_term[C])) == 8'h00;
    endproperty
    a_arr_c: assert property (p_arr_c) else $error("array pin wrong");
    property p_rd;
        ok && axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
endmodule
bind port_mode_mux port_mode_mux_asserts u_chk (.*);

/* test/port_mode_mux_bench.sv */
// port_mode_mux_bench: drives registers, modes and pads, checks pins and reads
// assumes pin_world as pad model and the checker bound to the block
`timescale 1ns/1ps
module port_mode_mux_bench;
    localparam int C = port_mode_pkg::PORT_C;
    localparam int E = port_mode_pkg::PORT_E;
    localparam int F = port_mode_pkg::PORT_F;
    localparam int G = port_mode_pkg::PORT_G;
    localparam logic [1:0] OK = port_mode_pkg::RESP_OKAY;
    // ======
    // stimulus and observation
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    port_mode_pkg::axi_req_t axi_req = '0;
    port_mode_pkg::axi_rsp_t axi_rsp;
    logic [15:0] host_addr = 16'h0000, data_port_out = 16'h0000, data_port_in;
    logic address_strobe = 1'b0, bus_8bit = 1'b0, data_port_en = 1'b0, data_port_drive = 1'b0;
    logic peripheral_select_a = 1'b0, peripheral_select_b = 1'b0, peri_drive = 1'b0;
    logic memory_map_periph;
    logic [2:0] scan_enable = 3'h0;
    logic [7:0] scan_pin_mask = 8'h00, peri_out = 8'h00, scan_out = 8'h00, scan_drive = 8'h00;
    logic [6:0][7:0] pin_in, pin_out, pin_oe_n, array_in, ext_lvl = '0, latch_in_mask = '0;
    logic [6:0][7:0] array_io_mask = '0, array_oe_term = '0, array_out = '0;
    logic [33:0] exp_q[$];
    logic [31:0] seed = 32'h591e88f4;
    int err_count = 0;
    int compares = 0;
    port_mode_mux u_dut (.*);
    pin_world u_pins (.*);
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // ======
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // compare enable and driven bits of one port
    task automatic pc(input int p, input logic [7:0] oe, input logic [7:0] o);
        chk({18'h0, pin_oe_n[p], pin_out[p] & ~oe}, {18'h0, oe, o & ~oe});
    endtask
    task automatic st();
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= {24'h0, d};
        axi_req.wstrb <= 4'hf;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1 && n < 200);
        axi_req.bready <= 1'b0;
        if (n >= 200) err_count++;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        exp_q.push_back({r, 24'h0, d});
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1 && n < 200);
        axi_req.rready <= 1'b0;
        if (n >= 200) err_count++;
    endtask
    // read monitor takes the oldest note at each answer
    always @(posedge core_clk) begin
        if (axi_rsp.rvalid === 1'b1 && axi_req.rready === 1'b1) begin
            chk({axi_rsp.rresp, axi_rsp.rdata}, exp_q.pop_front());
        end
    end
    initial begin
        #1000000;
        err_count++;
        end_of_test();
    end
    // ======
    // main sequence
    initial begin
        logic [7:0] dv, dm, tm;
        logic [15:0] ha;
        int p;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        st();
        chk({18'h0, pin_oe_n[0], pin_oe_n[G]}, 34'hffff);
        for (p = 0; p < 7; p++) begin
            rd(8'(4 * p), 8'h00, OK);
            rd(8'h40 + 8'(4 * p), 8'h00, OK);
            if (p < 3) rd(8'h20 + 8'(4 * p), 8'h00, OK);
        end
        rd(8'h80, 8'h00, OK);
        rd(8'h84, 8'h00, port_mode_pkg::RESP_SLVERR);
        wr(8'h0c, 8'hff);
        rd(8'h0c, port_mode_pkg::PORT_D_MASK, OK);
        // host I/O on every port with random data, direction and terms
        for (p = 0; p < 7; p++) begin
            dv = 8'(rnd());
            dm = 8'(rnd());
            tm = 8'(rnd());
            array_oe_term[p] <= tm;
            array_out <= 56'({rnd(), rnd()});
            ext_lvl[p] <= 8'(rnd());
            wr(8'h40 + 8'(4 * p), dv);
            wr(8'(4 * p), dm);
            st();
            if (p == port_mode_pkg::PORT_D) dm = dm & port_mode_pkg::PORT_D_MASK;
            if (p < 3 || p == F) dm = dm | tm;
            pc(p, ~dm, dv);
            rd(8'h60 + 8'(4 * p), (dv & dm) | (ext_lvl[p] & ~dm), OK);
        end
        // address out: direction and control set first
        array_oe_term <= '0;
        for (p = E; p < 7; p++) begin
            wr(8'h20 + 8'(4 * (p - E)), 8'hff);
            wr(8'(4 * p), 8'hff);
        end
        ha = 16'(rnd());
        host_addr <= ha;
        address_strobe <= 1'b1;
        st();
        address_strobe <= 1'b0;
        host_addr <= ~ha;
        st();
        pc(E, 8'h00, ha[7:0]);
        pc(F, 8'h00, ha[7:0]);
        pc(G, 8'h00, ha[15:8]);
        bus_8bit <= 1'b1;
        st();
        pc(G, 8'h00, ha[7:0]);
        wr(8'h18, 8'h00);
        st();
        pc(G, 8'hff, 8'h00);
        // array mode on port C; pins 7:6 take array input, direction set on pins 5:4
        array_io_mask[C] <= 8'hff;
        array_oe_term[C] <= 8'h0f;
        wr(8'h08, 8'h30);
        st();
        pc(C, 8'hc0, array_out[C]);
        // peripheral buffer on port F, each select in turn
        peri_drive <= 1'b1;
        peri_out <= 8'(rnd());
        wr(8'h80, 8'h80);
        rd(8'h80, 8'h80, OK);
        st();
        chk({33'h0, memory_map_periph}, 34'h1);
        pc(F, 8'hff, 8'h00);
        for (p = 0; p < 2; p++) begin
            peripheral_select_a <= (p == 0);
            peripheral_select_b <= (p == 1);
            st();
            pc(F, 8'h00, peri_out);
        end
        peripheral_select_b <= 1'b0;
        // data port owns F and G
        data_port_en <= 1'b1;
        data_port_out <= 16'(rnd());
        st();
        pc(F, 8'hff, 8'h00);
        pc(G, 8'hff, 8'h00);
        data_port_drive <= 1'b1;
        st();
        pc(G, 8'h00, data_port_out[15:8]);
        chk({18'h0, data_port_in}, {18'h0, data_port_out});
        // scan pins on E by each enable
        scan_pin_mask <= 8'h0f;
        scan_drive <= 8'hff;
        scan_out <= 8'(rnd());
        for (p = 0; p < 3; p++) begin
            scan_enable <= 3'(1 << p);
            st();
            pc(E, 8'h00, {ha[7:4], scan_out[3:0]});
        end
        // port A as strobe-latched address input, pad changes after the strobe
        wr(8'h00, 8'h00);
        latch_in_mask[0] <= 8'hff;
        ext_lvl[0] <= 8'h5a;
        address_strobe <= 1'b1;
        st();
        address_strobe <= 1'b0;
        ext_lvl[0] <= 8'ha5;
        st();
        chk({26'h0, array_in[0]}, 34'h5a);
        chk({26'h0, array_in[1]}, {26'h0, pin_in[1]});
        end_of_test();
    end
endmodule
